// ---- hw/dwp_params.svh ----
// constants for the dual wiper serial command port
`ifndef DWP_PARAMS_SVH
`define DWP_PARAMS_SVH
`define DWP_CLK_MHZ        50
`define DWP_BUSY_MS        12
`define DWP_BUSY_CYC       (`DWP_BUSY_MS * 1000 * `DWP_CLK_MHZ)
`define DWP_LOAD_NS        5000
`define DWP_LOAD_CYC       ((`DWP_LOAD_NS * `DWP_CLK_MHZ) / 1000)
`define DWP_MIDSCALE       8'h80
`define DWP_SHORT_LEN      5'h08
`define DWP_LONG_LEN       5'h10
`endif

// ---- hw/dwp_pkg.sv ----
// types for the dual wiper serial command port
package dwp_pkg;
  typedef enum logic [1:0] {
    DWP_OP_WR_WIPER  = 2'b00,
    DWP_OP_WR_STORED = 2'b01,
    DWP_OP_SAVE      = 2'b10,
    DWP_OP_RESTORE   = 2'b11
  } dwp_op_t;
  typedef struct packed {
    logic [1:0] op;
    logic [1:0] chan;
    logic [7:0] code;
  } dwp_frame_t;
  typedef enum logic [1:0] {
    DWP_ST_LOAD = 2'b00,
    DWP_ST_RUN  = 2'b01,
    DWP_ST_BUSY = 2'b10
  } dwp_state_t;
endpackage

// ---- hw/dwp_port.sv ----
// dual wiper serial command port, device side
`timescale 1ns/1ns
`default_nettype none
`include "dwp_params.svh"
module dwp_port
  import dwp_pkg::*;
#(
  parameter int BUSY_CYC = `DWP_BUSY_CYC,
  parameter int LOAD_CYC = `DWP_LOAD_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       sclk,
  input  wire logic       din,
  input  wire logic       cs_n,
  output var  logic [7:0] wiper_terminal_a,
  output var  logic [7:0] wiper_terminal_b,
  output var  logic       wiper_valid,
  output var  logic       store_busy
);
  logic [2:0]  sclk_s;
  logic [1:0]  din_s;
  logic [2:0]  cs_s;
  logic [15:0] shift;
  logic [4:0]  bit_cnt;
  logic [7:0]  wiper_a_position;
  logic [7:0]  wiper_b_position;
  logic [7:0]  stored_a_position;
  logic [7:0]  stored_b_position;
  logic [23:0] tmr;
  dwp_state_t  state;
  dwp_frame_t  frm;
  logic        sclk_rise;
  logic        cs_rise;
  logic        len_ok;
  logic        go;

  // two flops before use; third flop only feeds edge detection
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s <= 3'h0;
      din_s  <= 2'h0;
      cs_s   <= 3'h7;
    end else begin
      sclk_s <= {sclk_s[1:0], sclk};
      din_s  <= {din_s[0], din};
      cs_s   <= {cs_s[1:0], cs_n};
    end
  end

  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign cs_rise   = cs_s[1] & ~cs_s[2];

  // frame is taken as command byte then optional code byte, msb first
  always_comb begin
    if (bit_cnt == `DWP_SHORT_LEN) begin
      frm = dwp_frame_t'({shift[5:4], shift[1:0], 8'h00});
    end else begin
      frm = dwp_frame_t'({shift[13:12], shift[9:8], shift[7:0]});
    end
  end

  assign len_ok = (bit_cnt == `DWP_LONG_LEN) ||
                  (bit_cnt == `DWP_SHORT_LEN && frm.op[1]);
  // channel 00 and both-channel writes are ignored
  assign go = cs_rise && state != DWP_ST_LOAD && len_ok && frm.chan != 2'b00 &&
              !(frm.chan == 2'b11 && !frm.op[1]);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift   <= 16'h0000;
      bit_cnt <= 5'h00;
    end else if (cs_s[1]) begin
      bit_cnt <= 5'h00;
    end else if (sclk_rise) begin
      shift <= {shift[14:0], din_s[1]};
      if (bit_cnt != 5'h1f) begin
        bit_cnt <= bit_cnt + 5'h01; // extra clocks saturate, frame rejected
      end
    end
  end

  // stored copies; no real cell, flops reset to shipping midscale
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stored_a_position <= `DWP_MIDSCALE;
      stored_b_position <= `DWP_MIDSCALE;
    end else if (go && state == DWP_ST_RUN) begin
      unique case (dwp_op_t'(frm.op))
        DWP_OP_WR_STORED: begin
          if (frm.chan[0]) stored_a_position <= frm.code;
          if (frm.chan[1]) stored_b_position <= frm.code;
        end
        DWP_OP_SAVE: begin
          if (frm.chan[0]) stored_a_position <= wiper_a_position;
          if (frm.chan[1]) stored_b_position <= wiper_b_position;
        end
        default: ;
      endcase
    end
  end

  // wipers: code picks tap directly, 00 low end, ff high end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wiper_a_position <= 8'h00;
      wiper_b_position <= 8'h00;
    end else if (state == DWP_ST_LOAD && tmr == 24'h000000) begin
      wiper_a_position <= stored_a_position;
      wiper_b_position <= stored_b_position;
    end else if (go && frm.op == DWP_OP_WR_WIPER) begin
      if (frm.chan[0]) wiper_a_position <= frm.code;
      if (frm.chan[1]) wiper_b_position <= frm.code;
    end else if (go && frm.op == DWP_OP_RESTORE) begin
      if (frm.chan[0]) wiper_a_position <= stored_a_position;
      if (frm.chan[1]) wiper_b_position <= stored_b_position;
    end
  end

  // stored writes during busy are dropped, as the cell would be mid-program
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= DWP_ST_LOAD;
      tmr   <= 24'(LOAD_CYC - 1);
    end else begin
      unique case (state)
        DWP_ST_LOAD: begin
          if (tmr == 24'h000000) state <= DWP_ST_RUN;
          else tmr <= tmr - 24'h000001;
        end
        DWP_ST_RUN: begin
          if (go && frm.op inside {DWP_OP_WR_STORED, DWP_OP_SAVE}) begin
            state <= DWP_ST_BUSY;
            tmr   <= 24'(BUSY_CYC - 1);
          end
        end
        DWP_ST_BUSY: begin
          if (tmr == 24'h000000) state <= DWP_ST_RUN;
          else tmr <= tmr - 24'h000001;
        end
        default: state <= DWP_ST_RUN;
      endcase
    end
  end

  // registered wiper and status outputs only, nothing shifts back out
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wiper_terminal_a <= 8'h00;
      wiper_terminal_b <= 8'h00;
      wiper_valid      <= 1'b0;
      store_busy       <= 1'b0;
    end else begin
      wiper_terminal_a <= wiper_a_position;
      wiper_terminal_b <= wiper_b_position;
      wiper_valid      <= state != DWP_ST_LOAD;
      store_busy       <= state == DWP_ST_BUSY;
    end
  end

  // frm moves once the bit count clears on the decode edge, so checks use $past of it
  a_wiper_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    go && frm.op == DWP_OP_WR_WIPER && frm.chan == 2'b01
    |=> wiper_a_position == $past(frm.code) ##1 wiper_terminal_a == $past(frm.code, 2))
    else $error("wiper a not loaded");
  a_wiper_b_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    go && frm.op == DWP_OP_WR_WIPER && frm.chan == 2'b10
    |=> wiper_b_position == $past(frm.code) && $stable(wiper_a_position))
    else $error("wiper b not loaded");
  a_stored_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
    go && frm.op == DWP_OP_WR_WIPER |=> $stable(stored_a_position) && $stable(stored_b_position))
    else $error("stored changed by wiper write");
  a_stored_write: assert property (@(posedge core_clk) disable iff (!rst_n)
    go && state == DWP_ST_RUN && frm.op == DWP_OP_WR_STORED && frm.chan == 2'b10
    |=> stored_b_position == $past(frm.code) && $stable(wiper_b_position))
    else $error("stored b not written");
  a_busy_drop: assert property (@(posedge core_clk) disable iff (!rst_n)
    go && state == DWP_ST_BUSY && frm.op == DWP_OP_WR_STORED
    |=> $stable(stored_a_position) && $stable(stored_b_position))
    else $error("stored write taken while busy");
  a_save_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
    go && state == DWP_ST_RUN && frm.op == DWP_OP_SAVE && frm.chan == 2'b11
    |=> stored_a_position == $past(wiper_a_position)
        && stored_b_position == $past(wiper_b_position))
    else $error("save copy wrong");
  a_restore_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
    go && frm.op == DWP_OP_RESTORE && frm.chan == 2'b01
    |=> wiper_a_position == $past(stored_a_position))
    else $error("restore wrong");
  a_restore_chan_b: assert property (@(posedge core_clk) disable iff (!rst_n)
    go && frm.op == DWP_OP_RESTORE && frm.chan == 2'b10
    |=> wiper_b_position == $past(stored_b_position) && $stable(wiper_a_position))
    else $error("restore b wrong");
  a_bad_frame: assert property (@(posedge core_clk) disable iff (!rst_n)
    cs_rise && (frm.chan == 2'b00 || !len_ok)
    |=> $stable(wiper_a_position) && $stable(stored_a_position)
        && $stable(wiper_b_position) && $stable(stored_b_position))
    else $error("bad frame changed state");
  a_count_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    cs_s[1] |=> bit_cnt == 5'h00)
    else $error("bit count not cleared");
  a_busy_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    go && state == DWP_ST_RUN && frm.op == DWP_OP_SAVE |=> ##1 store_busy)
    else $error("busy not raised");
  a_busy_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == DWP_ST_BUSY && tmr != 24'h000000 |=> state == DWP_ST_BUSY)
    else $error("busy ended early");
  a_busy_end: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == DWP_ST_BUSY && tmr == 24'h000000 |=> state == DWP_ST_RUN)
    else $error("busy did not end");
  a_load_done: assert property (@(posedge core_clk) disable iff (!rst_n)
    state == DWP_ST_LOAD && tmr == 24'h000000 |=> ##1 wiper_valid)
    else $error("power-up load not finished");
  a_valid_stays: assert property (@(posedge core_clk) disable iff (!rst_n)
    wiper_valid |=> wiper_valid)
    else $error("valid dropped after load");

  // main scenarios: direct write, short copy, both-channel save, dropped store, busy end
  c_wiper_write: cover property (@(posedge core_clk) disable iff (!rst_n)
    go && frm.op == DWP_OP_WR_WIPER);
  c_short_copy: cover property (@(posedge core_clk) disable iff (!rst_n)
    go && bit_cnt == `DWP_SHORT_LEN);
  c_both_save: cover property (@(posedge core_clk) disable iff (!rst_n)
    go && frm.op == DWP_OP_SAVE && frm.chan == 2'b11);
  c_busy_drop: cover property (@(posedge core_clk) disable iff (!rst_n)
    go && state == DWP_ST_BUSY && frm.op == DWP_OP_WR_STORED);
  c_busy_done: cover property (@(posedge core_clk) disable iff (!rst_n)
    $fell(store_busy));
endmodule
`default_nettype wire

// ---- verif/dwp_host.sv ----
// serial host model driving the command port pins
`timescale 1ns/1ns
`default_nettype none
module dwp_host (
  input  wire logic core_clk,
  output var  logic sclk,
  output var  logic din,
  output var  logic cs_n
);
  initial begin
    sclk = 1'b0;
    din  = 1'b0;
    cs_n = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // top len bits msb first; clock stands low outside frames
  task automatic send(input logic [15:0] bits, input int len);
    cs_n = 1'b0;
    for (int i = 0; i < len; i++) begin
      din = bits[15-i];
      hold(4);
      sclk = 1'b1;
      hold(4);
      sclk = 1'b0;
    end
    hold(4);
    cs_n = 1'b1;
    din  = ~din; // no stale level once released
    hold(10);
  endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// self-checking bench for the dual wiper command port
`timescale 1ns/1ns
`default_nettype none
module testbench
  import dwp_pkg::*;
;
  logic       core_clk = 1'b0;
  logic       rst_n;
  logic       sclk;
  logic       din;
  logic       cs_n;
  logic [7:0] wiper_terminal_a;
  logic [7:0] wiper_terminal_b;
  logic       wiper_valid;
  logic       store_busy;
  int         num_errors;
  int         total_checks;
  int         cyc;

  // short busy time keeps a second store inside the busy window
  dwp_port #(.BUSY_CYC(400), .LOAD_CYC(10)) dwp_port_inst (
    .core_clk(core_clk), .rst_n(rst_n), .sclk(sclk), .din(din), .cs_n(cs_n),
    .wiper_terminal_a(wiper_terminal_a), .wiper_terminal_b(wiper_terminal_b),
    .wiper_valid(wiper_valid), .store_busy(store_busy));
  dwp_host dwp_host_inst (.core_clk(core_clk), .sclk(sclk), .din(din), .cs_n(cs_n));

  initial begin
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tx(dwp_op_t op, logic [1:0] ch, logic [7:0] code, int len);
    dwp_host_inst.send({2'b00, op, 2'b00, ch, code}, len);
  endtask
  task automatic ab(logic [7:0] a, logic [7:0] b);
    check("wiper a", wiper_terminal_a, a);
    check("wiper b", wiper_terminal_b, b);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 600 && store_busy !== 1'b0; i++) @(negedge core_clk);
  endtask

  task automatic t_powerup();
    for (int i = 0; i < 20 && wiper_valid !== 1'b1; i++) @(negedge core_clk);
    check("valid", {7'h00, wiper_valid}, 8'h01);
    ab(8'h80, 8'h80);
    $display("test powerup done");
  endtask

  task automatic t_wiper();
    tx(DWP_OP_WR_WIPER, 2'b01, 8'h00, 16);
    tx(DWP_OP_WR_WIPER, 2'b10, 8'hff, 16);
    ab(8'h00, 8'hff);
    tx(DWP_OP_WR_WIPER, 2'b00, 8'h5a, 16);
    tx(DWP_OP_WR_WIPER, 2'b01, 8'h5a, 8);
    tx(DWP_OP_WR_WIPER, 2'b11, 8'h5a, 16);
    tx(DWP_OP_WR_STORED, 2'b01, 8'h5a, 12);
    ab(8'h00, 8'hff);
    check("busy", {7'h00, store_busy}, 8'h00);
    tx(DWP_OP_RESTORE, 2'b01, 8'h00, 8);
    ab(8'h80, 8'hff);
    $display("test wiper done");
  endtask

  task automatic t_store();
    tx(DWP_OP_WR_STORED, 2'b01, 8'h3c, 16);
    check("busy", {7'h00, store_busy}, 8'h01);
    ab(8'h80, 8'hff);
    tx(DWP_OP_WR_STORED, 2'b10, 8'h77, 16);
    wait_idle();
    tx(DWP_OP_RESTORE, 2'b11, 8'h00, 8);
    ab(8'h3c, 8'h80);
    tx(DWP_OP_WR_WIPER, 2'b01, 8'h11, 16);
    tx(DWP_OP_WR_WIPER, 2'b10, 8'h22, 16);
    tx(DWP_OP_SAVE, 2'b11, 8'hee, 16);
    ab(8'h11, 8'h22);
    wait_idle();
    tx(DWP_OP_WR_WIPER, 2'b01, 8'h00, 16);
    tx(DWP_OP_WR_WIPER, 2'b10, 8'h00, 16);
    tx(DWP_OP_RESTORE, 2'b10, 8'h00, 16);
    ab(8'h00, 8'h22);
    tx(DWP_OP_RESTORE, 2'b11, 8'h00, 16);
    ab(8'h11, 8'h22);
    $display("test store done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    t_powerup();
    t_wiper();
    t_store();
    complete_run();
  end
endmodule
`default_nettype wire
